/* File: logic/gpm_pin_function_mux.sv */
`timescale 1ns/1ns
`include "gpm_cfg.svh"
module gpm_pin_function_mux #(
  parameter int PINS = `GPM_PIN_COUNT
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // management register port
  input wire gpm_pkg::gpm_idx_t reg_addr,
  input wire gpm_pkg::gpm_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output gpm_pkg::gpm_word_t reg_rdata,
  output logic reg_rvalid,
  // forwarding to other register spaces
  output gpm_pkg::gpm_word_t page_sel,
  output logic main_wr,
  output logic main_rd,
  input wire gpm_pkg::gpm_word_t main_rdata,
  output logic gpx_wr,
  output logic gpx_rd,
  input wire gpm_pkg::gpm_word_t gpx_rdata,
  // multipurpose pads
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  // dedicated functions behind the pads
  input wire logic [PINS-1:0] fn_out,
  input wire logic [PINS-1:0] fn_oe,
  output logic [PINS-1:0] fn_in,
  // power-hold pad
  input wire logic power_hold_pin_in,
  output logic power_hold_pin_out,
  output logic power_hold_pin_oe,
  // levels to neighbouring logic
  output logic led_float,
  output logic tw_float,
  output logic pulse_outputs_one_to_three_en
);
  import gpm_pkg::*;

  gpm_word_t page_d, page_q;
  gpm_word_t fsel1_d, fsel1_q;
  gpm_word_t fsel2_d, fsel2_q;
  logic [PINS-1:0] gp_out_d, gp_out_q;
  logic [PINS-1:0] gp_oe_d, gp_oe_q;
  gpm_word_t rdata_d, rdata_q;
  logic rvalid_d, rvalid_q;
  logic gp_sel;
  logic page_hit;
  logic ext_hit;
  logic [PINS-1:0] gpio_sel;
  gpm_word_t rd_word;

  // reserved general indices hold nothing and read back zero
  function automatic logic rsv_idx(input gpm_idx_t idx);
    return idx <= `GPM_IDX_RSV_HI || idx == `GPM_IDX_RSV30;
  endfunction

  assign gp_sel = page_q == `GPM_PAGE_GP;
  assign page_hit = reg_addr == `GPM_IDX_PAGE;
  assign ext_hit = reg_addr >= `GPM_IDX_EXT_LO && reg_addr <= `GPM_IDX_EXT_HI;

  // strobes for registers that live outside this block
  assign main_wr = reg_wr && !page_hit && !gp_sel;
  assign main_rd = reg_rd && !page_hit && !gp_sel;
  assign gpx_wr = reg_wr && gp_sel && ext_hit;
  assign gpx_rd = reg_rd && gp_sel && ext_hit;

  // pin ownership decode
  always_comb begin
    gpio_sel = '0;
    for (int i = 0; i < 8; i++) begin
      gpio_sel[i] = gpm_is_gpio(fsel1_q[2*i+:2]);
    end
    for (int i = 0; i < 4; i++) begin
      gpio_sel[8+i] = gpm_is_gpio(fsel2_q[2*i+:2]);
    end
    gpio_sel[12] = gpm_is_gpio(fsel2_q[`GPM_F2_SERIAL_LSB+:2]);
    gpio_sel[13] = gpio_sel[12];
  end

  // read decode
  always_comb begin
    rd_word = '0;
    if (page_hit) begin
      rd_word = page_q;
    end else if (!gp_sel) begin
      rd_word = main_rdata;
    end else if (ext_hit) begin
      rd_word = gpx_rdata;
    end else begin
      case (reg_addr)
        `GPM_IDX_FSEL1: begin
          rd_word = fsel1_q;
        end
        `GPM_IDX_FSEL2: begin
          rd_word = fsel2_q;
          rd_word[`GPM_F2_PH_IN] = power_hold_pin_in;
        end
        `GPM_IDX_GP_IN: begin
          rd_word[PINS-1:0] = pin_in;
        end
        `GPM_IDX_GP_OUT: begin
          rd_word[PINS-1:0] = gp_out_q;
        end
        `GPM_IDX_GP_OE: begin
          rd_word[PINS-1:0] = gp_oe_q;
        end
        default: begin
          rd_word = '0;
        end
      endcase
    end
  end

  // register next state
  always_comb begin
    page_d = page_q;
    fsel1_d = fsel1_q;
    fsel2_d = fsel2_q;
    gp_out_d = gp_out_q;
    gp_oe_d = gp_oe_q;
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    // soft reset drops back to the main page unless a page write comes in the same cycle, but leaves general bits alone
    if (soft_rst) begin
      page_d = `GPM_PAGE_MAIN;
    end
    if (reg_wr && page_hit) begin
      page_d = reg_wdata;
    end else if (reg_wr && gp_sel) begin
      case (reg_addr)
        `GPM_IDX_FSEL1: begin
          fsel1_d = reg_wdata;
        end
        `GPM_IDX_FSEL2: begin
          // the pin level bit is never stored
          fsel2_d = reg_wdata & ~`GPM_F2_RO_MASK;
        end
        `GPM_IDX_GP_OUT: begin
          gp_out_d = reg_wdata[PINS-1:0];
        end
        `GPM_IDX_GP_OE: begin
          gp_oe_d = reg_wdata[PINS-1:0];
        end
        default: begin
          // reserved, input and external indices store nothing here
          fsel1_d = fsel1_q;
        end
      endcase
    end
    if (reg_rd) begin
      rdata_d = rd_word;
    end
  end

  // only the hardware reset reaches the general page registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_q <= `GPM_PAGE_MAIN;
      fsel1_q <= `GPM_FSEL1_RST;
      fsel2_q <= `GPM_FSEL2_RST;
      gp_out_q <= `GPM_GP_OUT_RST;
      gp_oe_q <= `GPM_GP_OE_RST;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      page_q <= page_d;
      fsel1_q <= fsel1_d;
      fsel2_q <= fsel2_d;
      gp_out_q <= gp_out_d;
      gp_oe_q <= gp_oe_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign page_sel = page_q;

  // power-hold pad, direction bit is active low
  assign power_hold_pin_oe = !fsel2_q[`GPM_F2_PH_OE_N];
  assign power_hold_pin_out = fsel2_q[`GPM_F2_PH_DATA];
  assign led_float = fsel2_q[`GPM_F2_LED_FLOAT];
  assign tw_float = fsel2_q[`GPM_F2_TW_FLOAT];
  // software must keep this low while the daisy-chain input is in use
  assign pulse_outputs_one_to_three_en = fsel2_q[`GPM_F2_PULSE_EN];

  gpm_pin_cell_mux #(
    .PINS(PINS),
    .TW_MASK(`GPM_TW_PIN_MASK)
  ) u_gpm_pin_cell_mux (
    .sys_clk(sys_clk),
    .rst(rst),
    .gpio_sel(gpio_sel),
    .tw_float(tw_float),
    .gp_out(gp_out_q),
    .gp_oe(gp_oe_q),
    .fn_out(fn_out),
    .fn_oe(fn_oe),
    .fn_in(fn_in),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence page_write_s(logic [15:0] code);
    reg_wr && page_hit && reg_wdata == code;
  endsequence

  page_gp_a: assert property (page_write_s(`GPM_PAGE_GP) |=> gp_sel && page_sel == `GPM_PAGE_GP)
    else $error("general page not entered");
  page_main_a: assert property (page_write_s(`GPM_PAGE_MAIN) |=> !gp_sel && !gpx_wr && !gpx_rd)
    else $error("main page not restored");
  page_guard_a: assert property ((reg_wr && !gp_sel && !page_hit) |=> $stable(fsel1_q) && $stable(fsel2_q))
    else $error("general register written outside its page");
  main_fwd_a: assert property ((reg_rd && !gp_sel && !page_hit) |=> reg_rvalid && reg_rdata == $past(main_rdata))
    else $error("main page read not forwarded");
  sticky_bits_a: assert property ((soft_rst && !reg_wr) |=> $stable(gp_oe_q) && $stable(fsel2_q) && !gp_sel)
    else $error("general bits disturbed by soft reset");
  rsv_read_a: assert property ((reg_rd && gp_sel && rsv_idx(reg_addr))
    |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("reserved index read nonzero");
  fsel_reset_a: assert property ($rose(!rst) |-> fsel1_q == `GPM_FSEL1_RST && power_hold_pin_oe == 1'b0 && led_float)
    else $error("control reset value wrong");
  ph_drive_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2
    && !reg_wdata[`GPM_F2_PH_OE_N])
    |=> power_hold_pin_oe && power_hold_pin_out == $past(reg_wdata[`GPM_F2_PH_DATA]))
    else $error("power-hold output not taken from control bit");
  ph_level_a: assert property ((reg_rd && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> reg_rdata[`GPM_F2_PH_IN] == $past(power_hold_pin_in))
    else $error("power-hold level not reported");
  pin_level_a: assert property ((reg_rd && gp_sel && reg_addr == `GPM_IDX_GP_IN)
    |=> reg_rdata == {2'b00, $past(pin_in)})
    else $error("input register does not show pin levels");
  rsv_code_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL1 && reg_wdata[1:0] == 2'b01)
    |=> !gpio_sel[0] ##1 (pin_oe[0] == $past(fn_oe[0]) && pin_out[0] == $past(fn_out[0])))
    else $error("reserved code handed pin to software");
  pulse_en_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> pulse_outputs_one_to_three_en == $past(reg_wdata[`GPM_F2_PULSE_EN]))
    else $error("pulse output enable not written");

  // pages and forwarding
  page_read_a: assert property ((reg_rd && page_hit)
    |=> reg_rvalid && reg_rdata == $past(page_sel))
    else $error("page select read back wrong");
  gp_fwd_a: assert property ((reg_rd && gp_sel && ext_hit)
    |=> reg_rvalid && reg_rdata == $past(gpx_rdata))
    else $error("general page read not forwarded");
  page_keep_a: assert property ((!(reg_wr && page_hit) && !soft_rst) |=> $stable(page_sel))
    else $error("page select moved without a write");
  soft_page_a: assert property ((soft_rst && !(reg_wr && page_hit)) |=> page_sel == `GPM_PAGE_MAIN)
    else $error("soft reset left the general page selected");
  rvalid_pulse_a: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after the request");

  // stores of the general registers
  fsel1_store_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL1)
    |=> fsel1_q == $past(reg_wdata))
    else $error("pin control 1 not stored");
  fsel2_store_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> (fsel2_q | `GPM_F2_RO_MASK) == ($past(reg_wdata) | `GPM_F2_RO_MASK))
    else $error("pin control 2 not stored");
  ro_bit_a: assert property (!fsel2_q[`GPM_F2_PH_IN])
    else $error("read-only level bit was stored");
  gp_out_store_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_GP_OUT)
    |=> gp_out_q == $past(reg_wdata[PINS-1:0]))
    else $error("output register not stored");
  gp_oe_store_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_GP_OE)
    |=> gp_oe_q == $past(reg_wdata[PINS-1:0]))
    else $error("enable register not stored");
  rsv_write_a: assert property ((reg_wr && gp_sel && (rsv_idx(reg_addr) || reg_addr == `GPM_IDX_GP_IN))
    |=> $stable(fsel1_q) && $stable(fsel2_q) && $stable(gp_out_q) && $stable(gp_oe_q))
    else $error("reserved or input index changed a register");
  ext_write_a: assert property ((reg_wr && gp_sel && ext_hit)
    |=> $stable(fsel1_q) && $stable(fsel2_q) && $stable(gp_out_q) && $stable(gp_oe_q))
    else $error("forwarded index changed a local register");
  sticky_out_a: assert property ((soft_rst && !reg_wr) |=> $stable(fsel1_q) && $stable(gp_out_q))
    else $error("soft reset disturbed pin control or output bits");

  // pin ownership follows the stored codes
  clk_owner_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL1)
    |=> gpio_sel[7] == ($past(reg_wdata[15:14]) == 2'b11) && gpio_sel[4] == ($past(reg_wdata[9:8]) == 2'b11))
    else $error("two-wire clock pin owner wrong");
  sd_owner_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL1)
    |=> gpio_sel[3] == ($past(reg_wdata[7:6]) == 2'b11) && gpio_sel[0] == ($past(reg_wdata[1:0]) == 2'b11))
    else $error("signal detect pin owner wrong");
  serial_pair_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> gpio_sel[13:12] == {2{$past(reg_wdata[`GPM_F2_SERIAL_LSB+:2]) == 2'b11}})
    else $error("serial pins not moved together");
  pulse_owner_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> gpio_sel[11] == ($past(reg_wdata[7:6]) == 2'b11) && gpio_sel[8] == ($past(reg_wdata[1:0]) == 2'b11))
    else $error("pulse or two-wire data pin owner wrong");
  strobe_owner_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> gpio_sel[10] == ($past(reg_wdata[5:4]) == 2'b11) && gpio_sel[9] == ($past(reg_wdata[3:2]) == 2'b11))
    else $error("strobe or link fail pin owner wrong");
  ph_input_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2 && reg_wdata[`GPM_F2_PH_OE_N])
    |=> !power_hold_pin_oe)
    else $error("power-hold pin driven while set as input");
  float_bits_a: assert property ((reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL2)
    |=> tw_float == $past(reg_wdata[`GPM_F2_TW_FLOAT]) && led_float == $past(reg_wdata[`GPM_F2_LED_FLOAT]))
    else $error("float controls not taken from control 2");
  gp_pad_a: assert property ((gpio_sel[11] && gp_oe_q[11])
    |=> pin_oe[11] && pin_out[11] == $past(gp_out_q[11]))
    else $error("software pin not driven from output register");
  fn_level_a: assert property (!gpio_sel[1]
    |=> fn_in[1] == $past(pin_in[1]))
    else $error("signal detect level not passed to its function");

  gp_page_c: cover property (page_write_s(`GPM_PAGE_GP) ##2 reg_rd && reg_addr == `GPM_IDX_FSEL1);
  rsv_code_c: cover property (reg_wr && gp_sel && reg_addr == `GPM_IDX_FSEL1 && reg_wdata[1:0] == 2'b01);
  gp_pin_c: cover property (gpio_sel[11] && gp_oe_q[11] ##1 pin_oe[11]);
  ph_out_c: cover property (power_hold_pin_oe && power_hold_pin_out);
  soft_keep_c: cover property (soft_rst && gpio_sel[0]);
endmodule

/* File: logic/gpm_cfg.svh */
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// management register indices
`define GPM_IDX_PAGE 5'd31
`define GPM_IDX_RSV_HI 5'd12
`define GPM_IDX_FSEL1 5'd13
`define GPM_IDX_FSEL2 5'd14
`define GPM_IDX_GP_IN 5'd15
`define GPM_IDX_GP_OUT 5'd16
`define GPM_IDX_GP_OE 5'd17
`define GPM_IDX_EXT_LO 5'd18
`define GPM_IDX_EXT_HI 5'd29
`define GPM_IDX_RSV30 5'd30

// page-select codes
`define GPM_PAGE_MAIN 16'h0000
`define GPM_PAGE_GP 16'h0010

// reset values
`define GPM_FSEL1_RST 16'h0000
`define GPM_FSEL2_RST 16'h2600
`define GPM_GP_OUT_RST 14'h0000
`define GPM_GP_OE_RST 14'h0000

// fields of the second control register
`define GPM_F2_SERIAL_LSB 14
`define GPM_F2_PH_OE_N 13
`define GPM_F2_PH_DATA 12
`define GPM_F2_PH_IN 11
`define GPM_F2_TW_FLOAT 10
`define GPM_F2_LED_FLOAT 9
`define GPM_F2_PULSE_EN 8
`define GPM_F2_RO_MASK 16'h0800

// pin map: 0-3 signal detect, 4-7 two-wire clocks, 8 two-wire data,
// 9 link fail, 10 load/save, 11 pulse per second, 12 serial select, 13 serial data out
`define GPM_PIN_COUNT 14
`define GPM_TW_PIN_MASK 14'h01F0

`endif

/* File: logic/gpm_pkg.sv */
package gpm_pkg;

  typedef enum logic [1:0] {
    GPM_FN_DEDICATED = 2'b00,
    GPM_FN_RSV_A = 2'b01,
    GPM_FN_RSV_B = 2'b10,
    GPM_FN_GPIO = 2'b11
  } gpm_fn_e;

  typedef logic [15:0] gpm_word_t;
  typedef logic [4:0] gpm_idx_t;

  // reserved codes fall back to the dedicated function
  function automatic logic gpm_is_gpio(input logic [1:0] code);
    return gpm_fn_e'(code) == GPM_FN_GPIO;
  endfunction

endpackage

/* File: logic/gpm_pin_cell_mux.sv */
`timescale 1ns/1ns
`include "gpm_cfg.svh"
module gpm_pin_cell_mux #(
  parameter int PINS = `GPM_PIN_COUNT,
  parameter logic [PINS-1:0] TW_MASK = `GPM_TW_PIN_MASK
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // selection
  input wire logic [PINS-1:0] gpio_sel,
  input wire logic tw_float,
  // general purpose side
  input wire logic [PINS-1:0] gp_out,
  input wire logic [PINS-1:0] gp_oe,
  // dedicated function side
  input wire logic [PINS-1:0] fn_out,
  input wire logic [PINS-1:0] fn_oe,
  output logic [PINS-1:0] fn_in,
  // pads
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe
);
  logic [PINS-1:0] pin_out_d, pin_oe_d, fn_in_d;
  logic [PINS-1:0] pin_out_q, pin_oe_q, fn_in_q;
  logic [PINS-1:0] tw_high_float;

  always_comb begin
    // open-drain style: a high two-wire level is released, not driven
    tw_high_float = TW_MASK & fn_out & {PINS{tw_float}};
    pin_out_d = (gpio_sel & gp_out) | (~gpio_sel & fn_out);
    pin_oe_d = (gpio_sel & gp_oe) | (~gpio_sel & fn_oe & ~tw_high_float);
    // a pin lent to software reads as idle to its dedicated function
    fn_in_d = pin_in & ~gpio_sel;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      fn_in_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      fn_in_q <= fn_in_d;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign fn_in = fn_in_q;

  gp_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> pin_out == $past((gpio_sel & gp_out) | (~gpio_sel & fn_out)))
    else $error("pin output does not follow its selected source");
  gp_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> (pin_oe & $past(gpio_sel)) == ($past(gp_oe) & $past(gpio_sel)))
    else $error("software pin enable not applied");
  tw_float_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tw_float && fn_out[4] && !gpio_sel[4]) |=> !pin_oe[4])
    else $error("two-wire clock driven high while floating");
  fn_in_a: assert property (@(posedge sys_clk) disable iff (rst)
    gpio_sel[0] |=> !fn_in[0])
    else $error("signal detect seen while pin is general purpose");
endmodule

/* File: tb/tb_gpm_pin_function_mux.sv */
`timescale 1ns/1ns
module tb_gpm_pin_function_mux;
  import gpm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gpm_idx_t reg_addr = '0;
  gpm_word_t reg_wdata = '0;
  gpm_word_t main_rdata = '0;
  gpm_word_t gpx_rdata = '0;
  logic [13:0] pin_in = '0;
  logic [13:0] fn_out = '0;
  logic [13:0] fn_oe = '0;
  logic power_hold_pin_in = 1'b0;
  gpm_word_t reg_rdata, page_sel;
  logic reg_rvalid, main_wr, main_rd, gpx_wr, gpx_rd, power_hold_pin_out, power_hold_pin_oe;
  logic led_float, tw_float, pulse_outputs_one_to_three_en;
  logic [13:0] pin_out, pin_oe, fn_in;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] seed = 32'd49980;
  // reference model of the register page
  logic [15:0] m_page, m_c1, m_c2;
  logic [13:0] m_out, m_oe;

  gpm_pin_function_mux u_gpm_pin_function_mux (
    .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .page_sel(page_sel),
    .main_wr(main_wr), .main_rd(main_rd), .main_rdata(main_rdata), .gpx_wr(gpx_wr), .gpx_rd(gpx_rd),
    .gpx_rdata(gpx_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .fn_out(fn_out),
    .fn_oe(fn_oe), .fn_in(fn_in), .power_hold_pin_in(power_hold_pin_in),
    .power_hold_pin_out(power_hold_pin_out), .power_hold_pin_oe(power_hold_pin_oe),
    .led_float(led_float), .tw_float(tw_float),
    .pulse_outputs_one_to_three_en(pulse_outputs_one_to_three_en)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hard_reset();
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    m_page = 16'h0000;
    m_c1 = 16'h0000;
    m_c2 = 16'h2600;
    m_out = '0;
    m_oe = '0;
  endtask

  function automatic logic [15:0] exp_rd(input logic [4:0] a);
    if (a == 5'd31) return m_page;
    if (m_page != 16'h0010) return main_rdata;
    case (a)
      5'd13: return m_c1;
      5'd14: return {m_c2[15:12], power_hold_pin_in, m_c2[10:0]};
      5'd15: return {2'b00, pin_in};
      5'd16: return {2'b00, m_out};
      5'd17: return {2'b00, m_oe};
      default: return (a >= 5'd18 && a <= 5'd29) ? gpx_rdata : 16'h0000;
    endcase
  endfunction

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] fw;
    fw = {13'h0000, 1'b0, m_page != 16'h0010 && a != 5'd31, m_page == 16'h0010 && a >= 5'd18 && a <= 5'd29};
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    #1 chk({13'h0000, reg_rvalid, main_wr, gpx_wr}, fw);
    @(negedge sys_clk);
    reg_wr = 1'b0;
    if (a == 5'd31) m_page = d;
    else if (m_page == 16'h0010) begin
      case (a)
        5'd13: m_c1 = d;
        5'd14: m_c2 = d & 16'hF7FF;
        5'd16: m_out = d[13:0];
        5'd17: m_oe = d[13:0];
        default: ;
      endcase
    end
  endtask

  task automatic rd(input logic [4:0] a);
    logic [15:0] e;
    logic [15:0] fr;
    e = exp_rd(a);
    fr = {14'h0000, m_page != 16'h0010 && a != 5'd31, m_page == 16'h0010 && a >= 5'd18 && a <= 5'd29};
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 chk({14'h0000, main_rd, gpx_rd}, fr);
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask

  task automatic pads();
    logic [13:0] e_out, e_oe, e_in;
    logic [1:0] code;
    logic g;
    repeat (2) @(negedge sys_clk);
    for (int p = 0; p < 14; p++) begin
      if (p < 4) code = m_c1[2*p+:2];
      else if (p < 8) code = m_c1[8+2*(p-4)+:2];
      else if (p < 12) code = m_c2[2*(p-8)+:2];
      else code = m_c2[15:14];
      g = (code == 2'b11);
      e_out[p] = g ? m_out[p] : fn_out[p];
      e_oe[p] = g ? m_oe[p] : fn_oe[p] && !(p >= 4 && p <= 8 && m_c2[10] && fn_out[p]);
      e_in[p] = g ? 1'b0 : pin_in[p];
    end
    chk({2'b00, pin_out}, {2'b00, e_out});
    chk({2'b00, pin_oe}, {2'b00, e_oe});
    chk({2'b00, fn_in}, {2'b00, e_in});
    chk({11'h000, power_hold_pin_out, power_hold_pin_oe, led_float, tw_float, pulse_outputs_one_to_three_en},
        {11'h000, m_c2[12], !m_c2[13], m_c2[9], m_c2[10], m_c2[8]});
  endtask

  task automatic rnd_in();
    pin_in = 14'(xs());
    fn_out = 14'(xs());
    fn_oe = 14'(xs());
    power_hold_pin_in = 1'(xs());
    main_rdata = 16'(xs());
    gpx_rdata = 16'(xs());
  endtask

  initial begin
    hard_reset();
    pads();
    rnd_in();
    rd(5'd31);
    rd(5'd13);
    wr(5'd31, 16'h0010);
    chk(page_sel, m_page);
    rd(5'd13);
    rd(5'd14);
    // reserved places, plus the read-only input register
    for (int a = 0; a < 32; a++) begin
      if (a <= 12 || a == 30 || a == 15) begin
        wr(a[4:0], 16'(xs()));
        rd(a[4:0]);
      end
    end
    for (int i = 0; i < 24; i++) begin
      rnd_in();
      // first passes give every code on every field, including the reserved ones
      wr(5'd13, i < 4 ? {8{i[1:0]}} : 16'(xs()));
      wr(5'd14, i < 4 ? {8{i[1:0]}} : 16'(xs()));
      wr(5'd16, 16'(xs()));
      wr(5'd17, 16'(xs()));
      pads();
      rd(5'd14);
      rd(5'd15);
      rd(5'd16);
      rd(5'd17);
      rd(5'(18 + i % 12));
    end
    wr(5'd31, 16'h0000);
    chk(page_sel, 16'h0000);
    rd(5'd14);
    wr(5'd31, 16'h0010);
    @(negedge sys_clk);
    soft_rst = 1'b1;
    @(negedge sys_clk);
    soft_rst = 1'b0;
    m_page = 16'h0000;
    chk(page_sel, 16'h0000);
    wr(5'd13, 16'(xs()));
    wr(5'd31, 16'h0010);
    rd(5'd13);
    rd(5'd14);
    rd(5'd17);
    pads();
    hard_reset();
    wr(5'd31, 16'h0010);
    rd(5'd13);
    rd(5'd14);
    rd(5'd16);
    rd(5'd17);
    pads();
    report_and_stop();
  end
endmodule
